// ==== common/clock_ctrl_pkg.sv ====
// Register map, field layout, reset values and ratio decoding of the clock ratio and module stop block.
// Assumes a 32-bit APB slave with byte addresses and one aligned word per register.
package clock_ctrl_pkg;

  // Register byte addresses
  localparam logic [31:0] FREQ_CTRL_ADDR = 32'hFFFE0010;
  localparam logic [31:0] STBY_CTRL_ADDR = 32'hFFFE0408;

  // Register widths and reset values
  localparam int          FREQ_W           = 16;
  localparam int          STBY_W           = 8;
  localparam logic [15:0] FREQ_RESET       = 16'h0000;
  localparam logic [7:0]  STBY_RESET       = 8'h00;
  localparam logic [15:0] FREQ_WRITE_MASK  = 16'h137F;

  // Frequency control field positions
  localparam int CLK_PIN_CTRL_BIT = 12;
  localparam int PLL_RATIO_LSB    = 8;
  localparam int PLL_RATIO_W      = 2;
  localparam int CORE_DIV_LSB     = 4;
  localparam int RANGE_SEL_BIT    = 3;
  localparam int PERIPH_DIV_LSB   = 0;
  localparam int DIV_CODE_W       = 3;

  // Standby module control field positions
  localparam int PIN_FLOAT_BIT    = 7;
  localparam int MOD_STOP_LSB     = 0;
  localparam int MOD_COUNT        = 7;

  // Module stop bit indices inside the stop field
  localparam int FLASH_IDX        = 0;
  localparam int DAC_IDX          = 1;
  localparam int ADC_IDX          = 2;
  localparam int I2C_IDX          = 3;
  localparam int OUT_ENABLE_IDX   = 4;
  localparam int MAIN_TIMER_IDX   = 5;
  localparam int SECOND_TIMER_IDX = 6;

  // Field encodings
  localparam logic [1:0] PLL_RATIO_X2       = 2'h3;
  localparam logic [2:0] CORE_DIV_X1        = 3'h0;
  localparam logic [2:0] PERIPH_DIV_QUARTER = 3'h3;
  localparam logic [2:0] PLL_FACTOR_X1      = 3'h1;
  localparam logic [2:0] PLL_FACTOR_X2      = 3'h2;

  // Divider counter width and clock rate
  localparam int RATIO_W        = 4;
  localparam int CLK_PERIOD_NS  = 50;

  // Divide code to ratio of reference cycles per tick
  function automatic logic [3:0] divide_ratio(input logic [2:0] code);
    case (code)
      3'h0:    divide_ratio = 4'h1;
      3'h1:    divide_ratio = 4'h2;
      3'h2:    divide_ratio = 4'h3;
      3'h3:    divide_ratio = 4'h4;
      3'h4:    divide_ratio = 4'h6;
      3'h5:    divide_ratio = 4'h8;
      default: divide_ratio = 4'h1;
    endcase
  endfunction

  // PLL ratio code to multiplication factor
  function automatic logic [2:0] pll_factor(input logic [1:0] code);
    pll_factor = (code == PLL_RATIO_X2) ? PLL_FACTOR_X2 : PLL_FACTOR_X1;
  endfunction

endpackage

// ==== common/clock_tick_if.sv ====
// Carrier between the control logic and one tick divider: divide code out, tick back.
// Assumes both ends run on the same clock.
interface clock_tick_if;
  logic [2:0] divide_code;
  logic       tick;

  modport control (output divide_code, input tick);
  modport divider (input divide_code, output tick);
endinterface

// ==== rtl/tick_divider.sv ====
// Enable pulse divider: one tick every N reference cycles, N decoded from the divide code.
// Assumes the code comes from registers on the same clock.
module tick_divider (
  input wire logic            pclk,
  input wire logic            presetn,
  clock_tick_if.divider       tick_port
);

  logic [clock_ctrl_pkg::RATIO_W-1:0] count;
  logic                               tick_q;

  // Decode and wrap detection
  wire logic [clock_ctrl_pkg::RATIO_W-1:0] ratio      = clock_ctrl_pkg::divide_ratio(tick_port.divide_code);
  wire logic [clock_ctrl_pkg::RATIO_W-1:0] last_count = ratio - 4'h1;
  wire logic                               wrap       = (count >= last_count);

  // Counter; a shrinking ratio wraps at once instead of running past the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count  <= 4'h0;
      tick_q <= 1'b0;
    end else begin
      count  <= wrap ? 4'h0 : count + 4'h1;
      tick_q <= wrap;
    end
  end

  assign tick_port.tick = tick_q;

endmodule

// ==== rtl/module_clock_gate.sv ====
// Per-module clock gating: each stop bit removes the enable and the tick of its module.
// Assumes stop bits and the shared tick come from flops on the same clock.
module module_clock_gate #(
  parameter int N = 7
) (
  input  wire logic [N-1:0] stop,
  input  wire logic         shared_tick,
  output wire logic [N-1:0] clock_enable,
  output wire logic [N-1:0] clock_tick
);

  // One gate per module
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : gate
      assign clock_enable[i] = ~stop[i];
      assign clock_tick[i]   = shared_tick & ~stop[i];
    end
  endgenerate

endmodule

// ==== rtl/clock_ratio_and_module_stop.sv ====
// Clock ratio and module stop control: APB register slave, ratio decode, tick dividers and gating.
// Assumes one 20 MHz clock as reference and an APB master with 32-bit data.
// Function
// - Clock pin control bit set holds the external clock pin low.
// - PLL ratio code binary 11 selects multiplication by two.
// - Core divider code 000 runs the core clock at ratio one.
// - Range select zero selects high-frequency mode.
// - Peripheral divider code 011 gives one quarter of the reference rate.
// - Pin float bit zero keeps pin states during software standby.
// - Each stop bit one stops its module clock; zero lets it run.
// - Stop bits 6..0 map second timer, main timer, output enable, I2C, ADC, DAC, flash.
//
// The APB register port is this design's own decision.
module clock_ratio_and_module_stop (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic        software_standby,
  output logic             external_clock_output_pin,
  output logic      [2:0]  pll_multiplier,
  output logic             high_frequency_mode,
  output wire logic        core_clock_tick,
  output wire logic        peripheral_clock_tick,
  output wire logic [6:0]  module_clock_enable,
  output wire logic [6:0]  module_clock_tick,
  output wire logic        standby_pins_hold,
  output wire logic        standby_pins_float
);

  logic [15:0] frequency_control;
  logic [7:0]  standby_module_control;
  logic        error_q;
  logic        clock_toggle;

  // APB phase and address decode
  wire logic setup_phase  = psel & ~penable;
  wire logic access_phase = psel & penable;
  wire logic hit_freq     = (paddr == clock_ctrl_pkg::FREQ_CTRL_ADDR);
  wire logic hit_stby     = (paddr == clock_ctrl_pkg::STBY_CTRL_ADDR);
  wire logic mapped       = hit_freq | hit_stby;
  wire logic write_freq   = access_phase & pwrite & hit_freq;
  wire logic write_stby   = access_phase & pwrite & hit_stby;

  // Byte-lane merge; reserved frequency bits never store, so they read as zero
  wire logic [15:0] next_frequency_control =
    {pstrb[1] ? pwdata[15:8] : frequency_control[15:8],
     pstrb[0] ? pwdata[7:0]  : frequency_control[7:0]} & clock_ctrl_pkg::FREQ_WRITE_MASK;
  wire logic [7:0]  next_standby_module_control =
    pstrb[0] ? pwdata[7:0] : standby_module_control;

  // Read mux; unmapped addresses read zero
  wire logic [31:0] read_value =
    hit_freq ? {16'h0000, frequency_control} :
    hit_stby ? {24'h000000, standby_module_control} : 32'h00000000;

  // Field extraction
  wire logic       clock_pin_output_control = frequency_control[clock_ctrl_pkg::CLK_PIN_CTRL_BIT];
  wire logic [1:0] pll_ratio_select         =
    {frequency_control[clock_ctrl_pkg::PLL_RATIO_LSB+1], frequency_control[clock_ctrl_pkg::PLL_RATIO_LSB]};
  wire logic       pll_ratio_select_hi      = pll_ratio_select[1];
  wire logic       pll_ratio_select_lo      = pll_ratio_select[0];
  wire logic [2:0] core_clock_divider       =
    frequency_control[clock_ctrl_pkg::CORE_DIV_LSB +: clock_ctrl_pkg::DIV_CODE_W];
  wire logic       frequency_range_select   = frequency_control[clock_ctrl_pkg::RANGE_SEL_BIT];
  wire logic [2:0] peripheral_clock_divider =
    frequency_control[clock_ctrl_pkg::PERIPH_DIV_LSB +: clock_ctrl_pkg::DIV_CODE_W];
  wire logic       standby_pin_float        = standby_module_control[clock_ctrl_pkg::PIN_FLOAT_BIT];
  wire logic [6:0] module_stop              =
    standby_module_control[clock_ctrl_pkg::MOD_STOP_LSB +: clock_ctrl_pkg::MOD_COUNT];

  // Named stop bits, kept for readability of the mapping
  wire logic flash_stop              = module_stop[clock_ctrl_pkg::FLASH_IDX];
  wire logic dac_stop                = module_stop[clock_ctrl_pkg::DAC_IDX];
  wire logic adc_stop                = module_stop[clock_ctrl_pkg::ADC_IDX];
  wire logic i2c_controller_stop     = module_stop[clock_ctrl_pkg::I2C_IDX];
  wire logic output_enable_unit_stop = module_stop[clock_ctrl_pkg::OUT_ENABLE_IDX];
  wire logic main_timer_stop         = module_stop[clock_ctrl_pkg::MAIN_TIMER_IDX];
  wire logic second_timer_stop       = module_stop[clock_ctrl_pkg::SECOND_TIMER_IDX];

  // Stop vector rebuilt from the named bits in documented order
  wire logic [6:0] gate_stop = {second_timer_stop, main_timer_stop, output_enable_unit_stop,
                                i2c_controller_stop, adc_stop, dac_stop, flash_stop};

  // Register storage; zero-wait slave, so a write lands at the first access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frequency_control <= clock_ctrl_pkg::FREQ_RESET;
    end else if (write_freq) begin
      frequency_control <= next_frequency_control;
    end
  end

  // Standby register storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_module_control <= clock_ctrl_pkg::STBY_RESET;
    end else if (write_stby) begin
      standby_module_control <= next_standby_module_control;
    end
  end

  // Read data and error captured in the setup cycle so they come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      error_q <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= pwrite ? 32'h00000000 : read_value;
      error_q <= ~mapped;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access_phase & error_q;

  // Mode outputs decoded from the registers, one cycle behind a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_multiplier      <= clock_ctrl_pkg::PLL_FACTOR_X1;
      high_frequency_mode <= 1'b0;
    end else begin
      pll_multiplier      <= clock_ctrl_pkg::pll_factor({pll_ratio_select_hi, pll_ratio_select_lo});
      high_frequency_mode <= ~frequency_range_select;
    end
  end

  // Tick dividers for core and peripheral clocks
  clock_tick_if core_tick_bus ();
  clock_tick_if periph_tick_bus ();

  assign core_tick_bus.divide_code   = core_clock_divider;
  assign periph_tick_bus.divide_code = peripheral_clock_divider;

  tick_divider core_divider (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick_port (core_tick_bus)
  );

  tick_divider periph_divider (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick_port (periph_tick_bus)
  );

  assign core_clock_tick       = core_tick_bus.tick;
  assign peripheral_clock_tick = periph_tick_bus.tick;

  // External clock pin: toggles on every core tick, so runs at half the core tick rate, held low when disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_toggle              <= 1'b0;
      external_clock_output_pin <= 1'b0;
    end else begin
      clock_toggle              <= core_clock_tick ? ~clock_toggle : clock_toggle;
      external_clock_output_pin <= clock_pin_output_control ? 1'b0 : clock_toggle;
    end
  end

  // Per-module gating of the peripheral tick
  module_clock_gate #(
    .N (clock_ctrl_pkg::MOD_COUNT)
  ) gating (
    .stop         (gate_stop),
    .shared_tick  (peripheral_clock_tick),
    .clock_enable (module_clock_enable),
    .clock_tick   (module_clock_tick)
  );

  // Standby pin behaviour; float only when asked, otherwise pins hold
  assign standby_pins_hold  = software_standby & ~standby_pin_float;
  assign standby_pins_float = software_standby & standby_pin_float;

  // Checks on the block's own outputs
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  clock_pin_low_a: assert property (
    clock_pin_output_control |=> !external_clock_output_pin
  ) else $error("clock pin not held low while disabled");

  pll_ratio_a: assert property (
    (pll_ratio_select == clock_ctrl_pkg::PLL_RATIO_X2) |=> (pll_multiplier == 3'h2)
  ) else $error("pll ratio 11 did not give factor two");

  core_ratio_one_a: assert property (
    (core_clock_divider == clock_ctrl_pkg::CORE_DIV_X1) |=> core_clock_tick
  ) else $error("core tick missing at ratio one");

  range_mode_a: assert property (
    !frequency_range_select |=> high_frequency_mode
  ) else $error("range zero did not select high-frequency mode");

  periph_quarter_a: assert property (
    (peripheral_clock_tick && peripheral_clock_divider == 3'h3) ##1 (peripheral_clock_divider == 3'h3) [*3]
    |-> (!peripheral_clock_tick && !$past(peripheral_clock_tick) && !$past(peripheral_clock_tick, 2))
        ##1 peripheral_clock_tick
  ) else $error("peripheral tick not every fourth cycle");

  pins_hold_a: assert property (
    (software_standby && !standby_pin_float) |-> (standby_pins_hold && !standby_pins_float)
  ) else $error("pins not held in standby");

  stop_write_a: assert property (
    (write_stby && pstrb[0]) |=> (module_clock_enable == ~$past(pwdata[6:0]))
  ) else $error("module enables do not follow written stop bits");

  timer_mapping_a: assert property (
    module_clock_tick[5] |-> (!standby_module_control[5] && peripheral_clock_tick && module_clock_enable[5])
  ) else $error("main timer tick while stopped");

  freq_store_a: assert property (
    (write_freq && pstrb[1:0] == 2'h3) |=> (frequency_control == ($past(pwdata[15:0]) & 16'h137F))
  ) else $error("frequency control did not store the write");

  freq_readback_a: assert property (
    (setup_phase && hit_freq && !pwrite) |=> (prdata == {16'h0000, $past(frequency_control)})
  ) else $error("frequency control read back wrong");

  unmapped_error_a: assert property (
    (setup_phase && !mapped) |=> (penable |-> pslverr)
  ) else $error("unmapped access not flagged");

  // Mode decode and clock pin, the other half of each setting
  pll_default_a: assert property (
    (pll_ratio_select != clock_ctrl_pkg::PLL_RATIO_X2) |=> (pll_multiplier == 3'h1)
  ) else $error("pll ratio other than 11 did not give factor one");

  range_high_a: assert property (
    frequency_range_select |=> !high_frequency_mode
  ) else $error("range one still reports high-frequency mode");

  clock_pin_runs_a: assert property (
    !clock_pin_output_control |=> (external_clock_output_pin == $past(clock_toggle))
  ) else $error("enabled clock pin does not follow the toggle");

  clock_pin_toggle_a: assert property (
    core_clock_tick |=> (clock_toggle != $past(clock_toggle))
  ) else $error("clock pin toggle missed a core tick");

  // Ratio two proves the divider really skips cycles, not only ratio one
  core_ratio_two_a: assert property (
    (core_clock_tick && core_clock_divider == 3'h1) ##1 (core_clock_divider == 3'h1) [*2]
    |-> (core_clock_tick && !$past(core_clock_tick))
  ) else $error("core tick not every second cycle");

  // Standby pins and module gating
  pins_float_a: assert property (
    (software_standby && standby_pin_float) |-> (standby_pins_float && !standby_pins_hold)
  ) else $error("pins not released in standby with float set");

  pins_idle_a: assert property (
    !software_standby |-> (!standby_pins_hold && !standby_pins_float)
  ) else $error("standby pin control active outside standby");

  stop_gate_a: assert property (
    module_clock_tick == ({7{peripheral_clock_tick}} & ~standby_module_control[6:0])
  ) else $error("module ticks do not follow the stop bits");

  flash_mapping_a: assert property (
    module_clock_enable[clock_ctrl_pkg::FLASH_IDX] == !standby_module_control[0]
  ) else $error("flash enable not on stop bit zero");

  second_timer_map_a: assert property (
    module_clock_enable[clock_ctrl_pkg::SECOND_TIMER_IDX] == !standby_module_control[6]
  ) else $error("second timer enable not on stop bit six");

  // Register storage and bus answers
  stby_store_a: assert property (
    (write_stby && pstrb[0]) |=> (standby_module_control == $past(pwdata[7:0]))
  ) else $error("standby control did not store the write");

  stby_readback_a: assert property (
    (setup_phase && hit_stby && !pwrite) |=> (prdata == {24'h000000, $past(standby_module_control)})
  ) else $error("standby control read back wrong");

  freq_hold_a: assert property (
    !write_freq |=> $stable(frequency_control)
  ) else $error("frequency control changed without a write");

  stby_hold_a: assert property (
    !write_stby |=> $stable(standby_module_control)
  ) else $error("standby control changed without a write");

  unmapped_keep_a: assert property (
    (access_phase && !mapped) |=> ($stable(frequency_control) && $stable(standby_module_control))
  ) else $error("unmapped access changed a register");

  write_reads_zero_a: assert property (
    (setup_phase && pwrite) |=> (prdata == 32'h00000000)
  ) else $error("write transfer returned nonzero read data");

  prdata_hold_a: assert property (
    !setup_phase |=> $stable(prdata)
  ) else $error("read data moved outside a setup cycle");

  mapped_no_error_a: assert property (
    (setup_phase && mapped) |=> !pslverr
  ) else $error("mapped access flagged as error");

endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the clock ratio and module stop block, driven over APB.
// Assumes the package constants for addresses and a zero-wait slave that still answers via pready.
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk             = 1'b0;
  logic        presetn          = 1'b0;
  logic        psel             = 1'b0;
  logic        penable          = 1'b0;
  logic        pwrite           = 1'b0;
  logic [31:0] paddr            = 32'h0;
  logic [31:0] pwdata           = 32'h0;
  logic [3:0]  pstrb            = 4'h0;
  logic        software_standby = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        external_clock_output_pin;
  logic [2:0]  pll_multiplier;
  logic        high_frequency_mode;
  logic        core_clock_tick;
  logic        peripheral_clock_tick;
  logic [6:0]  module_clock_enable;
  logic [6:0]  module_clock_tick;
  logic        standby_pins_hold;
  logic        standby_pins_float;
  int          failures         = 0;
  int          n_compared       = 0;
  int          cycles           = 0;
  int          c_core, c_per, c_pin;
  int          c_mod [7];
  int          ratio [8]        = '{1, 2, 3, 4, 6, 8, 1, 1};
  logic [31:0] r;
  logic        e;
  localparam logic [31:0] FA = clock_ctrl_pkg::FREQ_CTRL_ADDR;
  localparam logic [31:0] SA = clock_ctrl_pkg::STBY_CTRL_ADDR;

  clock_ratio_and_module_stop u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .software_standby(software_standby),
    .external_clock_output_pin(external_clock_output_pin), .pll_multiplier(pll_multiplier),
    .high_frequency_mode(high_frequency_mode), .core_clock_tick(core_clock_tick),
    .peripheral_clock_tick(peripheral_clock_tick), .module_clock_enable(module_clock_enable),
    .module_clock_tick(module_clock_tick), .standby_pins_hold(standby_pins_hold),
    .standby_pins_float(standby_pins_float)
  );

  // Free-running 20 MHz clock
  always #25 pclk = ~pclk;

  // Hang guard, far above the under one thousand cycles the tests need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("BAD at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, 4'hF, rd, err);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, 4'h0, rd, err);
    check(rd, exp);
    check({31'h0, err}, 32'h0);
  endtask

  // Counts ticks, pin changes and per-module ticks over a window, sampled mid-cycle
  task automatic count(input int cyc);
    logic last;
    c_core = 0;
    c_per = 0;
    c_pin = 0;
    foreach (c_mod[i]) c_mod[i] = 0;
    @(negedge pclk);
    last = external_clock_output_pin;
    repeat (cyc) begin
      @(negedge pclk);
      if (core_clock_tick === 1'b1) c_core++;
      if (peripheral_clock_tick === 1'b1) c_per++;
      if (external_clock_output_pin !== last) c_pin++;
      last = external_clock_output_pin;
      foreach (c_mod[i]) if (module_clock_tick[i] === 1'b1) c_mod[i]++;
    end
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(FA, 32'h0);
    rd_chk(SA, 32'h0);
    check(32'(module_clock_enable), 32'h7F);
    $display("test reset values done");

    // Documented frequency setting, then mask and lane handling
    wr(FA, 32'h1303);
    rd_chk(FA, 32'h1303);
    count(48);
    check(32'(c_pin), 32'h0);
    check({31'h0, external_clock_output_pin}, 32'h0);
    check(32'(pll_multiplier), 32'h2);
    check({31'h0, high_frequency_mode}, 32'h1);
    check(32'(c_core), 32'h30);
    check(32'(c_per), 32'hC);
    wr(FA, 32'hFFFFFFFF);
    rd_chk(FA, 32'h137F);
    check({31'h0, high_frequency_mode}, 32'h0);
    apb(1'b1, FA, 32'h0, 4'h2, r, e);
    rd_chk(FA, 32'h007F);
    $display("test frequency setting done");

    // Every divide code on both dividers, pin running, every ratio code
    for (int c = 0; c < 8; c++) begin
      wr(FA, 32'((c % 4) * 256 + c * 16 + c));
      repeat (10) @(posedge pclk);
      count(48);
      check(32'(c_core), 32'(48 / ratio[c]));
      check(32'(c_per), 32'(48 / ratio[c]));
      check(32'(c_pin), 32'(48 / ratio[c]));
      check(32'(pll_multiplier), (c % 4 == 3) ? 32'h2 : 32'h1);
    end
    $display("test divide codes done");

    // Each stop bit alone: 6 second timer, 5 main timer, 4 output enable, 3 I2C, 2 ADC, 1 DAC, 0 flash
    for (int i = 0; i < 7; i++) begin
      wr(SA, 32'(1 << i));
      @(negedge pclk);
      check(32'(module_clock_enable), 32'(7'h7F ^ (7'h01 << i)));
    end
    wr(SA, 32'h5E);
    rd_chk(SA, 32'h5E);
    wr(FA, 32'h1303);
    software_standby <= 1'b1;
    count(48);
    check(32'(module_clock_enable), 32'h21);
    check(32'(c_mod[5]), 32'hC);
    check(32'(c_mod[0]), 32'hC);
    check(32'(c_mod[6] + c_mod[4] + c_mod[1]), 32'h0);
    check({31'h0, standby_pins_hold}, 32'h1);
    check({31'h0, standby_pins_float}, 32'h0);
    wr(SA, 32'hDE);
    @(negedge pclk);
    check({31'h0, standby_pins_hold}, 32'h0);
    check({31'h0, standby_pins_float}, 32'h1);
    @(posedge pclk);
    software_standby <= 1'b0;
    @(negedge pclk);
    check({31'h0, standby_pins_hold}, 32'h0);
    check({31'h0, standby_pins_float}, 32'h0);
    $display("test module stop done");

    // Unmapped address is refused and leaves both registers alone
    apb(1'b1, 32'hFFFE0014, 32'hFFFFFFFF, 4'hF, r, e);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 32'hFFFE040C, 32'h0, 4'h0, r, e);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
    rd_chk(FA, 32'h1303);
    rd_chk(SA, 32'hDE);
    $display("test unmapped access done");

    // Second reset in mid-run clears both registers
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(FA, 32'h0);
    rd_chk(SA, 32'h0);
    check(32'(module_clock_enable), 32'h7F);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
